// ---- rtl/frb_pkg.sv ----
// Purpose: Constants for the floating-point register bank and its control registers
// Assumes: Registers are 32-bit aligned words at full byte addresses
// Notes:   Field positions of the context control register are fixed here
package frb_pkg;

    // Bank geometry
    localparam int          FRB_NUM_SINGLE      = 32;
    localparam int          FRB_NUM_SAVED       = 16;

    // Register byte addresses
    localparam logic [31:0] FRB_ADDR_PWR_CTL    = 32'he000e00c;
    localparam logic [31:0] FRB_ADDR_ACC_CTL    = 32'he000ed88;
    localparam logic [31:0] FRB_ADDR_NS_ACC     = 32'he000ed8c;
    localparam logic [31:0] FRB_ADDR_CTX_CTL    = 32'he000ef34;
    localparam logic [31:0] FRB_ADDR_CTX_ADR    = 32'he000ef38;
    localparam logic [31:0] FRB_ADDR_DFLT_ST    = 32'he000ef3c;
    localparam logic [31:0] FRB_ADDR_INT_STATUS = 32'he000ef50;
    localparam logic [31:0] FRB_ADDR_INT_MASK   = 32'he000ef54;

    // Writable bits of each register
    localparam logic [31:0] FRB_MASK_ACC_CTL    = 32'h00f0ffff;
    localparam logic [31:0] FRB_MASK_NS_ACC     = 32'h00000cff;
    localparam logic [31:0] FRB_MASK_PWR_CTL    = 32'h00000cff;
    localparam logic [31:0] FRB_MASK_CTX_CTL    = 32'hd0000000;
    localparam logic [31:0] FRB_MASK_CTX_ADR    = 32'hfffffff8;
    localparam logic [31:0] FRB_MASK_DFLT_ST    = 32'h07c00000;
    localparam logic [3:0]  FRB_MASK_INT        = 4'hf;

    // Reset values
    localparam logic [31:0] FRB_RST_ACC_CTL     = 32'h00000000;
    localparam logic [31:0] FRB_RST_NS_ACC      = 32'h00000000;
    localparam logic [31:0] FRB_RST_PWR_CTL     = 32'h00000000;
    localparam logic [31:0] FRB_RST_CTX_CTL     = 32'hc0000000;
    localparam logic [31:0] FRB_RST_CTX_ADR     = 32'h00000000;
    localparam logic [31:0] FRB_RST_DFLT_ST     = 32'h00000000;
    localparam logic [31:0] FRB_RST_STATUS      = 32'h00000000;

    // Access control field positions
    localparam int          FRB_TEN_LSB         = 20;
    localparam int          FRB_ELEVEN_LSB      = 22;
    localparam int          FRB_NS_TEN_BIT      = 10;
    localparam int          FRB_NS_ELEVEN_BIT   = 11;
    localparam logic [1:0]  FRB_ACC_PRIV        = 2'h1;
    localparam logic [1:0]  FRB_ACC_FULL        = 2'h3;

    // Context control bits
    localparam int          FRB_CCR_AUTO_EN     = 31;
    localparam int          FRB_CCR_LAZY_EN     = 30;
    localparam int          FRB_CCR_CLRONRET    = 28;
    localparam int          FRB_CCR_LSPACT      = 0;

    // Status and control register fields
    localparam int          FRB_SCR_NZCV_LSB    = 28;
    localparam int          FRB_SCR_STICKY_LSB  = 0;

    // Interrupt status bits
    localparam int          FRB_INT_LAZY_SAVE   = 0;
    localparam int          FRB_INT_DISABLED    = 1;
    localparam int          FRB_INT_NS_DENIED   = 2;
    localparam int          FRB_INT_FP_EXC      = 3;

endpackage

// ---- rtl/frb_register_bank.sv ----
// Purpose: Floating-point register bank with status, context and access control registers
// Assumes: One fp operation class per cycle from the pipeline; register bus is a plain strobe port
// Notes:   Save area is held in flip-flops; exception nesting beyond one level is not tracked
module frb_register_bank
    import frb_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [31:0]  regAddr,
    input  wire logic [31:0]  regWrData,
    input  wire logic         regWrite,
    input  wire logic         regRead,
    output logic      [31:0]  regRdData,
    input  wire logic         privileged,
    input  wire logic         nonSecure,
    input  wire logic         singleRead,
    input  wire logic [4:0]   singleRdIndex,
    output logic      [31:0]  singleRdData,
    input  wire logic         singleWrite,
    input  wire logic [4:0]   singleWrIndex,
    input  wire logic [31:0]  singleWrData,
    input  wire logic         doubleRead,
    input  wire logic [3:0]   doubleRdIndex,
    output logic      [63:0]  doubleRdData,
    input  wire logic         doubleWrite,
    input  wire logic [3:0]   doubleWrIndex,
    input  wire logic [63:0]  doubleWrData,
    input  wire logic         quadRead,
    input  wire logic [2:0]   quadRdIndex,
    output logic      [127:0] quadRdData,
    input  wire logic         quadWrite,
    input  wire logic [2:0]   quadWrIndex,
    input  wire logic [127:0] quadWrData,
    input  wire logic         predWrite,
    input  wire logic [15:0]  predWrData,
    output logic      [15:0]  vectorPredicateReg,
    input  wire logic         fpStatusWrite,
    input  wire logic [31:0]  fpStatusWrData,
    output logic      [31:0]  fpStatusControl,
    input  wire logic         compareValid,
    input  wire logic [3:0]   compareFlags,
    input  wire logic         arithExcValid,
    input  wire logic [4:0]   arithExcFlags,
    input  wire logic         sysregToCoreMove,
    output logic      [3:0]   appStatusFlags,
    output logic              appStatusValid,
    input  wire logic         excEntry,
    input  wire logic [31:0]  excFrameAddr,
    input  wire logic         excReturn,
    input  wire logic         excReturnFpCtx,
    output logic              fpContextActive,
    output logic              fpFault,
    output logic              fpUnitEnabled,
    output logic      [31:0]  powerNonRetentive,
    output logic              irq
);

    typedef struct packed {
        logic [31:0][31:0] sreg;
        logic [15:0][31:0] saveS;
        logic [31:0]       saveStatus;
        logic [15:0]       savePred;
        logic              saveValid;
        logic [31:0]       fpStatus;
        logic [15:0]       predicate;
        logic [31:0]       accCtl;
        logic [31:0]       nsAcc;
        logic [31:0]       pwrCtl;
        logic [31:0]       ctxCtl;
        logic [31:0]       ctxAddr;
        logic [31:0]       dfltStatus;
        logic [3:0]        intStatus;
        logic [3:0]        intMask;
        logic              fpca;
        logic [31:0]       regRdData;
        logic [31:0]       singleRdData;
        logic [63:0]       doubleRdData;
        logic [127:0]      quadRdData;
        logic [3:0]        appFlags;
        logic              appValid;
        logic              fault;
        logic              unitEnabled;
        logic              irq;
    } frb_state_t;

    frb_state_t st;
    frb_state_t next_st;

    logic [1:0] tenField;
    logic [1:0] elevenField;
    logic       localGrant;
    logic       nsGrant;
    logic       fpOp;
    logic       fpOk;
    logic [3:0] events;

    // Access decision
    always_comb begin
        tenField    = st.accCtl[FRB_TEN_LSB +: 2];
        elevenField = st.accCtl[FRB_ELEVEN_LSB +: 2];
        localGrant  = (tenField == elevenField) &&
                      ((tenField == FRB_ACC_FULL) || ((tenField == FRB_ACC_PRIV) && privileged));
        nsGrant     = !nonSecure ||
                      (st.nsAcc[FRB_NS_TEN_BIT] && st.nsAcc[FRB_NS_ELEVEN_BIT]);
        fpOp        = singleWrite || doubleWrite || quadWrite || predWrite || fpStatusWrite ||
                      compareValid || arithExcValid || sysregToCoreMove ||
                      singleRead || doubleRead || quadRead;
        fpOk        = fpOp && localGrant && nsGrant;
    end

    always_comb begin
        next_st          = st;
        events           = 4'h0;
        next_st.appValid = 1'b0;
        next_st.fault    = fpOp && !fpOk;
        events[FRB_INT_DISABLED]  = fpOp && !localGrant;
        events[FRB_INT_NS_DENIED] = fpOp && localGrant && !nsGrant;

        // Lazy save on the handler's first fp operation
        if (fpOk && st.ctxCtl[FRB_CCR_LSPACT]) begin
            for (int i = 0; i < FRB_NUM_SAVED; i++) begin
                next_st.saveS[i] = st.sreg[i];
            end
            next_st.saveStatus                = st.fpStatus;
            next_st.savePred                  = st.predicate;
            next_st.saveValid                 = 1'b1;
            next_st.ctxCtl[FRB_CCR_LSPACT]    = 1'b0;
            events[FRB_INT_LAZY_SAVE]         = 1'b1;
        end

        // New context takes the default status value
        if (fpOk && !st.fpca && st.ctxCtl[FRB_CCR_AUTO_EN]) begin
            next_st.fpca     = 1'b1;
            next_st.fpStatus = st.dfltStatus;
        end

        // Bank writes share one storage; quad wins over double over single
        if (fpOk) begin
            if (quadWrite) begin
                for (int k = 0; k < 4; k++) begin
                    next_st.sreg[{quadWrIndex, 2'(k)}] = quadWrData[32*k +: 32];
                end
            end else if (doubleWrite) begin
                next_st.sreg[{doubleWrIndex, 1'b0}] = doubleWrData[31:0];
                next_st.sreg[{doubleWrIndex, 1'b1}] = doubleWrData[63:32];
            end else if (singleWrite) begin
                next_st.sreg[singleWrIndex] = singleWrData;
            end
            if (predWrite) begin
                next_st.predicate = predWrData;
            end
            if (fpStatusWrite) begin
                next_st.fpStatus = fpStatusWrData;
            end
            if (compareValid) begin
                next_st.fpStatus[FRB_SCR_NZCV_LSB +: 4] = compareFlags;
            end
            if (arithExcValid) begin
                next_st.fpStatus[FRB_SCR_STICKY_LSB +: 5] =
                    next_st.fpStatus[FRB_SCR_STICKY_LSB +: 5] | arithExcFlags;
                events[FRB_INT_FP_EXC] = |arithExcFlags;
            end
            if (sysregToCoreMove) begin
                next_st.appFlags = st.fpStatus[FRB_SCR_NZCV_LSB +: 4];
                next_st.appValid = 1'b1;
            end
        end

        // Registered bank reads
        if (singleRead && fpOk) begin
            next_st.singleRdData = st.sreg[singleRdIndex];
        end
        if (doubleRead && fpOk) begin
            next_st.doubleRdData = {st.sreg[{doubleRdIndex, 1'b1}], st.sreg[{doubleRdIndex, 1'b0}]};
        end
        if (quadRead && fpOk) begin
            for (int k = 0; k < 4; k++) begin
                next_st.quadRdData[32*k +: 32] = st.sreg[{quadRdIndex, 2'(k)}];
            end
        end

        // Exception entry
        if (excEntry) begin
            if (st.fpca && st.ctxCtl[FRB_CCR_AUTO_EN] && localGrant) begin
                next_st.ctxAddr = excFrameAddr & FRB_MASK_CTX_ADR;
                if (st.ctxCtl[FRB_CCR_LAZY_EN]) begin
                    next_st.ctxCtl[FRB_CCR_LSPACT] = 1'b1;
                    next_st.saveValid              = 1'b0;
                end else begin
                    for (int i = 0; i < FRB_NUM_SAVED; i++) begin
                        next_st.saveS[i] = st.sreg[i];
                    end
                    next_st.saveStatus = st.fpStatus;
                    next_st.savePred   = st.predicate;
                    next_st.saveValid  = 1'b1;
                end
            end
            next_st.fpca = 1'b0;
        end else if (excReturn) begin
            if (st.saveValid) begin
                for (int i = 0; i < FRB_NUM_SAVED; i++) begin
                    next_st.sreg[i] = st.saveS[i];
                end
                next_st.fpStatus  = st.saveStatus;
                next_st.predicate = st.savePred;
            end else if (st.ctxCtl[FRB_CCR_CLRONRET] && !st.ctxCtl[FRB_CCR_LSPACT]) begin
                for (int i = 0; i < FRB_NUM_SAVED; i++) begin
                    next_st.sreg[i] = 32'h00000000;
                end
                next_st.fpStatus  = 32'h00000000;
                next_st.predicate = 16'h0000;
            end
            next_st.ctxCtl[FRB_CCR_LSPACT] = 1'b0;
            next_st.saveValid              = 1'b0;
            next_st.fpca                   = excReturnFpCtx;
        end

        // Register bus, aligned words only
        next_st.regRdData = 32'h00000000;
        if (regRead) begin
            unique case (regAddr)
                FRB_ADDR_PWR_CTL:    next_st.regRdData = st.pwrCtl;
                FRB_ADDR_ACC_CTL:    next_st.regRdData = st.accCtl;
                FRB_ADDR_NS_ACC:     next_st.regRdData = st.nsAcc;
                FRB_ADDR_CTX_CTL:    next_st.regRdData = st.ctxCtl;
                FRB_ADDR_CTX_ADR:    next_st.regRdData = st.ctxAddr;
                FRB_ADDR_DFLT_ST:    next_st.regRdData = st.dfltStatus;
                FRB_ADDR_INT_STATUS: next_st.regRdData = {28'h0000000, st.intStatus};
                FRB_ADDR_INT_MASK:   next_st.regRdData = {28'h0000000, st.intMask};
                default:             next_st.regRdData = 32'h00000000;
            endcase
        end
        next_st.intStatus = st.intStatus;
        if (regWrite) begin
            unique case (regAddr)
                FRB_ADDR_PWR_CTL:    next_st.pwrCtl     = regWrData & FRB_MASK_PWR_CTL;
                FRB_ADDR_ACC_CTL:    next_st.accCtl     = regWrData & FRB_MASK_ACC_CTL;
                FRB_ADDR_NS_ACC:     next_st.nsAcc      = regWrData & FRB_MASK_NS_ACC;
                FRB_ADDR_CTX_CTL:    next_st.ctxCtl     = (regWrData & FRB_MASK_CTX_CTL) |
                                                          (next_st.ctxCtl & ~FRB_MASK_CTX_CTL);
                FRB_ADDR_CTX_ADR:    next_st.ctxAddr    = regWrData & FRB_MASK_CTX_ADR;
                FRB_ADDR_DFLT_ST:    next_st.dfltStatus = regWrData & FRB_MASK_DFLT_ST;
                FRB_ADDR_INT_STATUS: next_st.intStatus = st.intStatus & ~regWrData[3:0];
                FRB_ADDR_INT_MASK:   next_st.intMask   = regWrData[3:0] & FRB_MASK_INT;
                default:             next_st.intMask   = next_st.intMask;
            endcase
        end

        // Set wins over write-one-to-clear
        next_st.intStatus   = next_st.intStatus | events;
        next_st.irq         = |(next_st.intStatus & next_st.intMask);
        next_st.unitEnabled = (next_st.accCtl[FRB_TEN_LSB +: 2] == next_st.accCtl[FRB_ELEVEN_LSB +: 2]) &&
                              (next_st.accCtl[FRB_TEN_LSB +: 2] != 2'h0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st            <= '0;
            st.accCtl     <= FRB_RST_ACC_CTL;
            st.nsAcc      <= FRB_RST_NS_ACC;
            st.pwrCtl     <= FRB_RST_PWR_CTL;
            st.ctxCtl     <= FRB_RST_CTX_CTL;
            st.ctxAddr    <= FRB_RST_CTX_ADR;
            st.dfltStatus <= FRB_RST_DFLT_ST;
            st.fpStatus   <= FRB_RST_STATUS;
        end else begin
            st <= next_st;
        end
    end

    assign regRdData          = st.regRdData;
    assign singleRdData       = st.singleRdData;
    assign doubleRdData       = st.doubleRdData;
    assign quadRdData         = st.quadRdData;
    assign vectorPredicateReg = st.predicate;
    assign fpStatusControl    = st.fpStatus;
    assign appStatusFlags     = st.appFlags;
    assign appStatusValid     = st.appValid;
    assign fpContextActive    = st.fpca;
    assign fpFault            = st.fault;
    assign fpUnitEnabled      = st.unitEnabled;
    assign powerNonRetentive  = st.pwrCtl;
    assign irq                = st.irq;

endmodule

// ---- verification/frb_core_model.sv ----
// Purpose: Pipeline side issuing fp operations to the bank
// Assumes: One operation for each command pulse
// Notes:   Idle data lines toggle so stale values are never trusted
module frb_core_model (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         go,
    input  wire logic [3:0]   kind,
    input  wire logic [4:0]   idx,
    input  wire logic [127:0] data,
    output logic      [10:0]  stb,
    output logic      [4:0]   opIdx,
    output logic      [127:0] opData
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge clk) begin
        if (rst) begin
            stb    <= 11'h0;
            opIdx  <= 5'h0;
            opData <= 128'h0;
        end else if (go) begin
            stb    <= 11'h1 << kind;
            opIdx  <= idx;
            opData <= data;
        end else begin
            stb    <= 11'h0;
            opData <= ~opData;
        end
    end
endmodule

// ---- verification/frb_register_bank_asserts.sv ----
// Purpose: Port-level checks of the register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Attached to the bank by bind
module frb_register_bank_asserts (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regRdData,
    input wire logic        privileged,
    input wire logic        nonSecure,
    input wire logic        compareValid,
    input wire logic [3:0]  compareFlags,
    input wire logic [31:0] fpStatusControl,
    input wire logic        sysregToCoreMove,
    input wire logic [3:0]  appStatusFlags,
    input wire logic        appStatusValid,
    input wire logic        excEntry,
    input wire logic        excReturn,
    input wire logic        fpContextActive,
    input wire logic        fpFault,
    input wire logic        fpUnitEnabled,
    input wire logic [31:0] powerNonRetentive
);
    logic accOk;
    assign accOk = (regWrData[23:22] == regWrData[21:20]) && (regWrData[21:20] != 2'h0);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence accWr;
        regWrite && regAddr == 32'he000ed88;
    endsequence
    sequence pwrWr;
        regWrite && regAddr == 32'he000e00c;
    endsequence
    sequence moveAnswer;
        ##1 appStatusValid != fpFault;
    endsequence
    rd_idle_a: assert property (!$past(regRead) |-> regRdData == 32'h0)
        else $error("read data not zero outside a read");
    rd_unmapped_a: assert property (regRead && regAddr == 32'he000ef40 |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    acc_enable_a: assert property (accWr |=> fpUnitEnabled == $past(accOk))
        else $error("unit enable does not follow access fields");
    pwr_copy_a: assert property (pwrWr |=> powerNonRetentive == ($past(regWrData) & 32'h00000cff))
        else $error("power control not reflected");
    cmp_flags_a: assert property (compareValid && fpContextActive && !excReturn
        |=> fpFault || fpStatusControl[31:28] == $past(compareFlags))
        else $error("compare flags not loaded");
    move_answer_a: assert property (sysregToCoreMove |-> moveAnswer)
        else $error("move gave no answer");
    move_flags_a: assert property (appStatusValid
        |-> $past(sysregToCoreMove) && appStatusFlags == $past(fpStatusControl[31:28]))
        else $error("moved flags wrong");
    fault_cause_a: assert property (fpFault
        |-> !$past(fpUnitEnabled) || $past(nonSecure) || !$past(privileged))
        else $error("fault while access granted");
    entry_close_a: assert property (excEntry && fpContextActive && fpUnitEnabled && privileged
        && !nonSecure |=> !fpContextActive)
        else $error("context still active after entry");
endmodule

bind frb_register_bank frb_register_bank_asserts u_chk (.*);

// ---- verification/frb_register_bank_tb_top.sv ----
// Purpose: Self-checking bench of the register bank
// Assumes: Pipeline model issues ops, bench drives register bus
// Notes:   Expectations are literal values plus bench copies of the single registers (sm, sv)
module frb_register_bank_tb_top
    import frb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ADDR_PWR = 32'he000e00c;
    localparam logic [31:0] ADDR_ACC = 32'he000ed88;
    localparam logic [31:0] ADDR_NSA = 32'he000ed8c;
    localparam logic [31:0] ADDR_CTX = 32'he000ef34;
    localparam logic [31:0] ADDR_CAD = 32'he000ef38;
    localparam logic [31:0] ADDR_DFL = 32'he000ef3c;
    localparam logic [31:0] ADDR_IST = 32'he000ef50;
    localparam logic [31:0] ADDR_IMK = 32'he000ef54;
    logic         clk, rst, regWrite, regRead, privileged, nonSecure, go;
    logic         excEntry, excReturn, excReturnFpCtx, appStatusValid, fpContextActive;
    logic         fpFault, fpUnitEnabled, irq;
    logic [31:0]  regAddr, regWrData, excFrameAddr, regRdData, singleRdData, fpStatusControl;
    logic [31:0]  powerNonRetentive, scr, svScr;
    logic [3:0]   kind, appStatusFlags;
    logic [4:0]   idx, opIdx;
    logic [10:0]  stb;
    logic [15:0]  vectorPredicateReg;
    logic [63:0]  doubleRdData, dv;
    logic [127:0] data, opData, quadRdData, qv;
    logic [31:0]  sm [32];
    logic [31:0]  sv [16];
    int           error_cnt, total_checks, q, n;

    frb_core_model u_core (.clk, .rst, .go, .kind, .idx, .data, .stb, .opIdx, .opData);
    frb_register_bank dut (.clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
        .privileged, .nonSecure, .singleRead(stb[1]), .singleRdIndex(opIdx), .singleRdData,
        .singleWrite(stb[0]), .singleWrIndex(opIdx), .singleWrData(opData[31:0]),
        .doubleRead(stb[3]), .doubleRdIndex(opIdx[3:0]), .doubleRdData, .doubleWrite(stb[2]),
        .doubleWrIndex(opIdx[3:0]), .doubleWrData(opData[63:0]), .quadRead(stb[5]),
        .quadRdIndex(opIdx[2:0]), .quadRdData, .quadWrite(stb[4]), .quadWrIndex(opIdx[2:0]),
        .quadWrData(opData), .predWrite(stb[10]), .predWrData(opData[15:0]), .vectorPredicateReg,
        .fpStatusWrite(stb[9]), .fpStatusWrData(opData[31:0]), .fpStatusControl,
        .compareValid(stb[6]), .compareFlags(opData[3:0]), .arithExcValid(stb[8]),
        .arithExcFlags(opData[4:0]), .sysregToCoreMove(stb[7]), .appStatusFlags, .appStatusValid,
        .excEntry, .excFrameAddr, .excReturn, .excReturnFpCtx, .fpContextActive, .fpFault,
        .fpUnitEnabled, .powerNonRetentive, .irq);

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr   <= a;
        regWrData <= d;
        regWrite  <= 1'b1;
        @(posedge clk);
        regWrite  <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    task automatic op(input logic [3:0] k, input logic [4:0] i, input logic [127:0] d);
        @(posedge clk);
        go   <= 1'b1;
        kind <= k;
        idx  <= i;
        data <= d;
        @(posedge clk);
        go   <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic final_report;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
    initial begin
        {regWrite, regRead, nonSecure, go, excEntry, excReturn, excReturnFpCtx} = '0;
        {regAddr, regWrData, excFrameAddr, kind, idx, data} = '0;
        rst = 1'b1;
        privileged = 1'b1;
        void'($urandom(86));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(ADDR_CTX, 32'hc0000000);
        rd(ADDR_ACC, 32'h0);
        rd(32'he000ef40, 32'h0);
        wr(ADDR_IMK, 32'hf);
        op(4'h0, 5'h3, 128'h1);
        chk(fpFault, 1'b1);
        rd(ADDR_IST, 32'h2);
        chk(irq, 1'b1);
        wr(ADDR_IST, 32'h2);
        tick();
        chk(irq, 1'b0);
        wr(ADDR_DFL, 32'hffffffff);
        rd(ADDR_DFL, 32'h07c00000);
        wr(ADDR_ACC, 32'h00f00000);
        #1 chk(fpUnitEnabled, 1'b1);
        for (n = 0; n < FRB_NUM_SINGLE; n++) begin
            sm[n] = $urandom;
            op(4'h0, n[4:0], {96'h0, sm[n]});
        end
        scr = 32'h07c00000;
        chk(fpStatusControl, scr);
        chk(fpContextActive, 1'b1);
        for (n = 0; n < 16; n++) begin
            op(4'h3, n[4:0], 128'h0);
            chk(doubleRdData, {sm[2*n+1], sm[2*n]});
        end
        n = $urandom_range(15);
        dv = {$urandom, $urandom};
        op(4'h2, n[4:0], {64'h0, dv});
        {sm[2*n+1], sm[2*n]} = dv;
        op(4'h1, 5'(2*n+1), 128'h0);
        chk(singleRdData, sm[2*n+1]);
        q = $urandom_range(7);
        qv = {$urandom, $urandom, $urandom, $urandom};
        op(4'h4, q[4:0], qv);
        op(4'h5, q[4:0], 128'h0);
        chk(quadRdData, qv);
        for (n = 0; n < 4; n++) begin
            sm[4*q+n] = qv[32*n+:32];
            op(4'h1, 5'(4*q+n), 128'h0);
            chk(singleRdData, sm[4*q+n]);
        end
        for (n = 0; n < 16; n++) begin
            op(4'h6, 5'h0, 128'(n));
            chk(fpStatusControl[31:28], n[3:0]);
            op(4'h7, 5'h0, 128'h0);
            chk({appStatusValid, appStatusFlags}, {1'b1, n[3:0]});
        end
        op(4'h8, 5'h0, 128'h05);
        op(4'h8, 5'h0, 128'h12);
        scr = {4'hf, 28'h7c00017};
        chk(fpStatusControl, scr);
        rd(ADDR_IST, 32'h8);
        wr(ADDR_IMK, 32'h0);
        tick();
        chk(irq, 1'b0);
        wr(ADDR_IMK, 32'hf);
        tick();
        chk(irq, 1'b1);
        wr(ADDR_IST, 32'h8);
        tick();
        chk(irq, 1'b0);
        wr(ADDR_PWR, 32'hffffffff);
        #1 chk(powerNonRetentive, 32'h00000cff);
        op(4'ha, 5'h0, 128'ha5a5);
        chk(vectorPredicateReg, 16'ha5a5);
        for (n = 0; n < 16; n++) sv[n] = sm[n];
        svScr = scr;
        @(posedge clk);
        excEntry     <= 1'b1;
        excFrameAddr <= 32'h20001237;
        @(posedge clk);
        excEntry <= 1'b0;
        rd(ADDR_CTX, 32'hc0000001);
        rd(ADDR_CAD, 32'h20001230);
        chk(fpContextActive, 1'b0);
        op(4'h0, 5'h0, 128'h0);
        chk(fpStatusControl, 32'h07c00000);
        rd(ADDR_CTX, 32'hc0000000);
        rd(ADDR_IST, 32'h1);
        wr(ADDR_IST, 32'hf);
        @(posedge clk);
        excReturn      <= 1'b1;
        excReturnFpCtx <= 1'b1;
        @(posedge clk);
        excReturn <= 1'b0;
        #1 chk(fpContextActive, 1'b1);
        chk(fpStatusControl, svScr);
        chk(vectorPredicateReg, 16'ha5a5);
        for (n = 0; n < 16; n++) begin
            op(4'h1, n[4:0], 128'h0);
            chk(singleRdData, sv[n]);
        end
        @(posedge clk);
        nonSecure <= 1'b1;
        op(4'h1, 5'h5, 128'h0);
        chk(fpFault, 1'b1);
        rd(ADDR_IST, 32'h4);
        wr(ADDR_NSA, 32'h00000c00);
        op(4'h1, 5'h5, 128'h0);
        chk({fpFault, singleRdData}, {1'b0, sm[5]});
        op(4'h9, 5'h0, 128'(dv[31:0]));
        chk(fpStatusControl, dv[31:0]);
        wr(ADDR_ACC, 32'h00500000);
        privileged <= 1'b0;
        op(4'h1, 5'h5, 128'h0);
        chk(fpFault, 1'b1);
        rd(ADDR_IST, 32'h6);
        final_report();
    end
endmodule
